//--- verilog/sspt_pkg.sv
// Constants, field layout and types for the secondary port transmit formatter
package sspt_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_FORMAT_CFG = 8'h1b;
  localparam logic [7:0] ADDR_OFFSET_CFG = 8'h1c;
  localparam logic [7:0] ADDR_ROUTE_CFG  = 8'h1d;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [7:0] OFFSET_WR_MASK  = 8'h1f;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_LAUNCH_EDGE = 7;
  localparam int BIT_IDLE_FILL   = 6;
  localparam int BIT_LAST_HOLD   = 5;
  localparam int KEEPER_HI       = 4;
  localparam int KEEPER_LO       = 3;
  localparam int BIT_INT_FSYNC   = 2;
  localparam int BIT_INT_BCLK    = 1;
  localparam int BIT_PULSE_WIDTH = 0;
  localparam int DELAY_HI        = 4;

  // ----------------------------------------
  // Frame geometry
  // ----------------------------------------
  localparam logic [5:0] WLEN_16     = 6'h10;
  localparam logic [5:0] WLEN_20     = 6'h14;
  localparam logic [5:0] WLEN_24     = 6'h18;
  localparam logic [5:0] WLEN_32     = 6'h20;
  localparam logic [3:0] TDM_SLOTS   = 4'h8;
  localparam logic [3:0] PAIR_SLOTS  = 4'h2;
  localparam logic [1:0] PULSE_ONE   = 2'h1;
  localparam logic [1:0] PULSE_TWO   = 2'h2;
  localparam logic [5:0] STD_I2S_LAG = 6'h01;

  typedef enum logic [1:0] {
    FMT_TDM = 2'h0,
    FMT_I2S = 2'h1,
    FMT_LJ  = 2'h2
  } sspt_format_type;

  typedef enum logic [1:0] {
    KEEP_OFF  = 2'h0,
    KEEP_ON   = 2'h1,
    KEEP_LSB  = 2'h2,
    KEEP_LSB3 = 2'h3
  } sspt_keeper_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_DELAY = 3'h2,
    ST_SHIFT = 3'h4
  } sspt_state_type;

  typedef struct packed {
    logic [2:0]  chan;
    logic [31:0] data;
  } sspt_sample_type;

  function automatic logic [5:0] sspt_wlen(input logic [1:0] code);
    case (code)
      2'h0:    return WLEN_16;
      2'h1:    return WLEN_20;
      2'h2:    return WLEN_24;
      default: return WLEN_32;
    endcase
  endfunction

endpackage

//--- verilog/sspt_fifo.sv
// Sample FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
module sspt_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire do_wr   = in_valid && in_ready;
  wire do_load = (count != '0) && (!out_valid || out_ready);

  assign in_ready = (count != DEPTH[AW:0]);

  always_ff @(posedge ref_clk)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      wr_ptr <= do_wr ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= do_load ? rd_ptr + 1'b1 : rd_ptr;
      count  <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_load};
      if (do_load)
      begin
        out_valid <= 1'b1;
        out_data  <= mem[rd_ptr];
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule

//--- verilog/sspt_tx_format.sv
// Transmit formatter of the secondary audio serial port
//
// Notes on behaviour
// - Launch-edge bit clear: data changes on edge set by clock polarity.
// - Launch-edge bit set: data launches on opposite edge, half bit later.
// - Unused bit cycles drive zero, or high impedance when fill bit set.
// - Last bit held full period, or half period then released when set.
// - Keeper field: off, on, on for LSB cycle, on for LSB plus half.
// - Controller mode: internal frame sync used when its select bit set.
// - Controller mode: internal bit clock used when its select bit set.
// - Slot-multiplexed frame pulse is one or two bit periods wide.
// - Slot 0 MSB delayed 0 to 31 bits, both halves in stereo formats.
// - Each channel 1..8 goes to secondary data pin when its bit set.
// - Format field: slot-multiplexed, standard two-channel, left-justified.
// - Word length field selects 16, 20, 24 or 32 bits.
// - Bit clock polarity bit sets default launch edge only; bclk_out is not inverted.
`timescale 1ns/1ps
module sspt_tx_format
  import sspt_pkg::*;
#(
  parameter int BCLK_HALF_DIV = 4,
  parameter int FIFO_DEPTH    = 16
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset,
  // Register port
  input  wire logic            reg_wr,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  output logic [7:0]           reg_rdata,
  // Port setup held elsewhere
  input  wire logic            controller_mode,
  input  wire logic [1:0]      frame_format_select,
  input  wire logic [1:0]      word_length_select,
  input  wire logic            bit_clock_polarity,
  // Link clocks
  input  wire logic            ext_bclk,
  input  wire logic            ext_fsync,
  output logic                 bclk_out,
  output logic                 fsync_out,
  // Data pins
  output logic                 dout_pri,
  output logic                 dout_pri_oe,
  output logic                 secondary_data_pin,
  output logic                 secondary_data_pin_oe,
  output logic                 keeper_en,
  // Sample stream
  input  wire logic            s_valid,
  output logic                 s_ready,
  input  wire sspt_sample_type s_sample
);
  localparam int DW = $clog2(BCLK_HALF_DIV);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] fmt_cfg;
  logic [7:0] ofs_cfg;
  logic [7:0] route_cfg;

  wire wr_fmt   = reg_wr && (reg_addr == ADDR_FORMAT_CFG);
  wire wr_ofs   = reg_wr && (reg_addr == ADDR_OFFSET_CFG);
  wire wr_route = reg_wr && (reg_addr == ADDR_ROUTE_CFG);
  wire [7:0] next_rdata = (reg_addr == ADDR_FORMAT_CFG) ? fmt_cfg :
                          (reg_addr == ADDR_OFFSET_CFG) ? ofs_cfg :
                          (reg_addr == ADDR_ROUTE_CFG)  ? route_cfg : CFG_RESET;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      fmt_cfg   <= CFG_RESET;
      ofs_cfg   <= CFG_RESET;
      route_cfg <= CFG_RESET;
      reg_rdata <= CFG_RESET;
    end
    else
    begin
      if (wr_fmt)
        fmt_cfg <= reg_wdata;
      if (wr_ofs)
        ofs_cfg <= reg_wdata & OFFSET_WR_MASK;
      if (wr_route)
        route_cfg <= reg_wdata;
      reg_rdata <= next_rdata;
    end
  end

  wire             fill_hiz  = fmt_cfg[BIT_IDLE_FILL];
  wire             hold_half = fmt_cfg[BIT_LAST_HOLD];
  sspt_keeper_type keep_mode;
  assign keep_mode = sspt_keeper_type'(fmt_cfg[KEEPER_HI:KEEPER_LO]);
  wire [5:0] delay_cfg = {1'b0, ofs_cfg[DELAY_HI:0]};

  // ----------------------------------------
  // Bit clock selection and edges
  // ----------------------------------------
  logic bclk_meta, bclk_sync, fs_meta, fs_sync, bclk_prev, fs_last;
  logic [DW-1:0] div_cnt;

  wire use_int_bclk = controller_mode && fmt_cfg[BIT_INT_BCLK];
  wire use_int_fs   = controller_mode && fmt_cfg[BIT_INT_FSYNC];
  wire bclk_sel     = use_int_bclk ? bclk_out : bclk_sync;
  wire bclk_rise    = bclk_sel && !bclk_prev;
  wire bclk_fall    = !bclk_sel && bclk_prev;
  // Default launch is the falling edge; polarity and edge select each flip it
  wire launch_rise  = bit_clock_polarity ^ fmt_cfg[BIT_LAUNCH_EDGE];
  wire launch_tick  = launch_rise ? bclk_rise : bclk_fall;
  wire half_tick    = launch_rise ? bclk_fall : bclk_rise;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      {bclk_meta, bclk_sync, fs_meta, fs_sync} <= 4'h0;
      bclk_prev <= 1'b0;
      div_cnt   <= '0;
      bclk_out  <= 1'b0;
    end
    else
    begin
      bclk_meta <= ext_bclk;
      bclk_sync <= bclk_meta;
      fs_meta   <= ext_fsync;
      fs_sync   <= fs_meta;
      bclk_prev <= bclk_sel;
      div_cnt   <= (div_cnt == DW'(BCLK_HALF_DIV - 1)) ? '0 : div_cnt + 1'b1;
      if (div_cnt == DW'(BCLK_HALF_DIV - 1))
        bclk_out <= !bclk_out;
    end
  end

  // ----------------------------------------
  // Frame timing
  // ----------------------------------------
  sspt_format_type fmt;
  assign fmt = sspt_format_type'(frame_format_select);
  wire       is_tdm    = (fmt == FMT_TDM);
  wire       is_i2s    = (fmt == FMT_I2S);
  wire [5:0] wlen      = sspt_wlen(word_length_select);
  wire [3:0] nslots    = is_tdm ? TDM_SLOTS : PAIR_SLOTS;
  wire [8:0] frame_len = 9'(wlen * nslots);
  wire [1:0] pulse_w   = fmt_cfg[BIT_PULSE_WIDTH] ? PULSE_TWO : PULSE_ONE;
  logic [8:0] frm_cnt;

  wire int_left  = launch_tick && (frm_cnt == frame_len - 9'h1);
  wire int_right = launch_tick && !is_tdm && (frm_cnt == {3'h0, wlen} - 9'h1);
  wire fs_rise   = launch_tick && fs_sync && !fs_last;
  wire fs_fall   = launch_tick && !fs_sync && fs_last;
  wire ext_left  = is_i2s ? fs_fall : fs_rise;
  wire ext_right = !is_tdm && (is_i2s ? fs_rise : fs_fall);
  wire evt_left  = use_int_fs ? int_left : ext_left;
  wire evt_right = use_int_fs ? int_right : ext_right;
  wire next_fsync = is_tdm ? (frm_cnt < {7'h0, pulse_w}) :
                    ((frm_cnt < {3'h0, wlen}) ^ is_i2s);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      frm_cnt   <= '0;
      fs_last   <= 1'b0;
      fsync_out <= 1'b0;
    end
    else
    begin
      if (launch_tick)
        frm_cnt <= int_left ? '0 : frm_cnt + 9'h1;
      if (launch_tick)
        fs_last <= fs_sync;
      fsync_out <= controller_mode && next_fsync;
    end
  end

  // ----------------------------------------
  // Serializer
  // ----------------------------------------
  sspt_state_type  state;
  sspt_sample_type head;
  logic [5:0]  delay_cnt, bit_cnt;
  logic [3:0]  slot, dly_slot;
  logic [31:0] shreg;
  logic        tx_active, cur_sec, release_lsb, keep_tail, head_valid, dly_run;

  wire       start      = evt_left || evt_right;
  wire [5:0] load_delay = delay_cnt_init(delay_cfg, is_i2s);
  wire       last_bit   = (bit_cnt == wlen - 6'h1);
  wire       slot_end   = (state == ST_SHIFT) && last_bit;
  // Delay runs beside the shifter, so the word before still sends its tail
  wire       dly_done   = dly_run && (delay_cnt == 6'h0);
  wire [3:0] next_slot  = start ? {3'h0, evt_right} : (dly_done ? dly_slot : slot + 4'h1);
  wire       slot_begin = launch_tick && ((start && load_delay == 6'h0) ||
                          (!start && dly_done) ||
                          (!start && !dly_run && slot_end && is_tdm && next_slot < nslots));
  wire       take       = slot_begin && head_valid && (head.chan == next_slot[2:0]);
  wire       tx_on      = (state == ST_SHIFT) && tx_active;
  wire       lsb_now    = tx_on && last_bit;

  function automatic logic [5:0] delay_cnt_init(input logic [5:0] d, input logic lag);
    return lag ? d + STD_I2S_LAG : d;
  endfunction

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      {delay_cnt, bit_cnt, slot, dly_slot, shreg} <= '0;
      {tx_active, cur_sec, dly_run} <= 3'h0;
    end
    else if (launch_tick)
    begin
      if (start && load_delay != 6'h0)
      begin
        dly_run   <= 1'b1;
        dly_slot  <= next_slot;
        delay_cnt <= load_delay - 6'h1;
      end
      else if (start || dly_done)
        dly_run <= 1'b0;
      else if (dly_run)
        delay_cnt <= delay_cnt - 6'h1;
      if (slot_begin)
      begin
        state     <= ST_SHIFT;
        slot      <= next_slot;
        bit_cnt   <= '0;
        tx_active <= take;
        shreg     <= head.data;
        cur_sec   <= route_cfg[next_slot[2:0]];
      end
      else if (state == ST_SHIFT && !slot_end)
      begin
        bit_cnt <= bit_cnt + 6'h1;
        shreg   <= {shreg[30:0], 1'b0};
      end
      else if (start || dly_run)
      begin
        state     <= ST_DELAY;
        tx_active <= 1'b0;
      end
      else
      begin
        state     <= ST_IDLE;
        tx_active <= 1'b0;
      end
    end
  end

  sspt_fifo #(
    .WIDTH ($bits(sspt_sample_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (s_valid),
    .in_ready  (s_ready),
    .in_data   (s_sample),
    .out_valid (head_valid),
    .out_ready (take),
    .out_data  (head)
  );

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Half-bit release and keeper tail both end on the next opposite edge
  wire next_keeper = (keep_mode == KEEP_ON) ||
                     ((keep_mode == KEEP_LSB || keep_mode == KEEP_LSB3) && lsb_now) ||
                     ((keep_mode == KEEP_LSB3) && keep_tail);
  wire drive_bit  = tx_on && !release_lsb;
  wire fill_oe    = !fill_hiz;
  wire next_p_oe  = (tx_on && !cur_sec) ? !release_lsb : fill_oe;
  wire next_s_oe  = (tx_on && cur_sec) ? !release_lsb : fill_oe;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      {release_lsb, keep_tail, keeper_en} <= 3'h0;
      {dout_pri, dout_pri_oe, secondary_data_pin, secondary_data_pin_oe} <= 4'h0;
    end
    else
    begin
      release_lsb <= launch_tick ? 1'b0 : (release_lsb || (half_tick && lsb_now && hold_half));
      keep_tail   <= half_tick ? 1'b0 : (keep_tail || (launch_tick && lsb_now));
      keeper_en   <= next_keeper;
      dout_pri    <= drive_bit && !cur_sec && shreg[31];
      dout_pri_oe <= next_p_oe;
      secondary_data_pin    <= drive_bit && cur_sec && shreg[31];
      secondary_data_pin_oe <= next_s_oe;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [1:0] fs_ticks;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      fs_ticks <= '0;
    else
      fs_ticks <= fsync_out ? fs_ticks + {1'b0, launch_tick} : '0;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_launch_default_edge: assert property (launch_tick && !fmt_cfg[BIT_LAUNCH_EDGE] |->
    (bit_clock_polarity ? bclk_rise : bclk_fall)) else $error("default launch edge wrong");
  a_launch_opposite_edge: assert property (launch_tick && fmt_cfg[BIT_LAUNCH_EDGE] |->
    (bit_clock_polarity ? bclk_fall : bclk_rise)) else $error("opposite launch edge wrong");
  a_fill_zero_drive: assert property (!tx_on && !fill_hiz |=>
    dout_pri_oe && !dout_pri && secondary_data_pin_oe && !secondary_data_pin)
    else $error("unused cycle not driven low");
  a_fill_hiz_release: assert property (!tx_on && fill_hiz |=>
    !dout_pri_oe && !secondary_data_pin_oe) else $error("unused cycle not released");
  a_lsb_full_hold: assert property (lsb_now && !hold_half && !cur_sec |=> dout_pri_oe)
    else $error("last bit dropped early");
  a_lsb_half_release: assert property (half_tick && lsb_now && hold_half && !cur_sec
    |-> ##2 !dout_pri_oe) else $error("last bit not released at half period");
  a_keeper_off_on: assert property (keep_mode == KEEP_OFF |=> !keeper_en)
    else $error("keeper on while disabled");
  a_keeper_lsb_only: assert property (keep_mode == KEEP_LSB |=> keeper_en == $past(lsb_now))
    else $error("keeper not tied to last bit");
  a_int_frame_start: assert property (use_int_fs && int_left |-> evt_left)
    else $error("internal frame sync ignored");
  a_ext_bclk_edges: assert property (!use_int_bclk && launch_tick |-> bclk_sync != bclk_prev)
    else $error("external bit clock not followed");
  a_pulse_width_bits: assert property (controller_mode && is_tdm && $fell(fsync_out) |->
    fs_ticks == pulse_w) else $error("frame pulse width wrong");
  a_slot0_msb_delay: assert property (launch_tick && start && load_delay != 6'h0 |=>
    dly_run && delay_cnt == $past(load_delay) - 6'h1) else $error("delay not loaded");
  a_route_pin_sel: assert property (tx_on |-> cur_sec == route_cfg[slot[2:0]])
    else $error("channel on wrong pin");
  a_cfg_reset_zero: assert property ($past(reset) |-> fmt_cfg == CFG_RESET &&
    ofs_cfg == CFG_RESET && route_cfg == CFG_RESET) else $error("config not reset");

  c_secondary_pin: cover property (tx_on && cur_sec);
  c_half_release: cover property (release_lsb && tx_on);
  c_keeper_tail: cover property (keep_tail && keeper_en);
  c_right_half: cover property (evt_right && take);
endmodule

//--- test/sspt_host_model.sv
// Host receiver model: makes the link clocks and captures slot words
`timescale 1ns/1ps
module sspt_host_model (
  // Device data pins
  input  wire logic dout_pri,
  input  wire logic dout_pri_oe,
  input  wire logic secondary_data_pin,
  input  wire logic secondary_data_pin_oe,
  input  wire logic keeper_en,
  // Link clocks toward the device
  output logic      ext_bclk,
  output logic      ext_fsync
);
  logic [31:0]  pd, po, sd, so, kp;
  logic [162:0] word;
  event         word_done;

  initial
  begin
    ext_bclk  = 1'b0;
    ext_fsync = 1'b0;
  end

  // Sync level at tick i; negative ticks lead in at the idle level
  function automatic logic fs_level(input logic [1:0] f, input int i, input int wl);
    if (f == 2'h0)
      return i == 0;
    if (f == 2'h1)
      return i < 0 || i >= wl;
    return i >= 0 && i < wl;
  endfunction

  // Undriven bits read as 0 here; the enable mask says what was driven
  task automatic take(input int k, input int s, input int wl);
    if (k == 0)
      {pd, po, sd, so, kp} = '0;
    pd = {pd[30:0], dout_pri & dout_pri_oe};
    po = {po[30:0], dout_pri_oe};
    sd = {sd[30:0], secondary_data_pin & secondary_data_pin_oe};
    so = {so[30:0], secondary_data_pin_oe};
    kp = {kp[30:0], keeper_en};
    if (k == wl - 1)
    begin
      word = {s[2:0], kp, po, pd, so, sd};
      -> word_done;
    end
  endtask

  // Clock stands still between frames; sample 30 ns after each launch edge
  task automatic run_frame(input logic [1:0] f, input logic [1:0] w, input logic rise,
                           input int dl);
    int wl;
    int p;
    wl = (w == 2'h3) ? 32 : 16 + 4 * w;
    ext_bclk = rise;
    #200;
    for (int i = -2; i < ((f == 2'h0) ? 8 : 2) * wl + dl + 2; i++)
    begin
      ext_bclk  = ~rise;
      ext_fsync = fs_level(f, i, wl);
      #40 ext_bclk = rise;
      #30 p = i - 1 - dl;
      if (p >= 0 && p < ((f == 2'h0) ? 8 : 2) * wl)
        take(p % wl, p / wl, wl);
      #10;
    end
  endtask
endmodule

//--- test/test_sspt_tx_format.sv
// Self-checking bench of the secondary port transmit formatter
`timescale 1ns/1ps
module test_sspt_tx_format;
  import sspt_pkg::*;

  logic ref_clk, reset, reg_wr, controller_mode, bit_clock_polarity, s_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg0, route;
  logic [1:0] frame_format_select, word_length_select;
  logic [4:0] off;
  logic ext_bclk, ext_fsync, dout_pri, dout_pri_oe, keeper_en;
  logic secondary_data_pin, secondary_data_pin_oe;
  sspt_sample_type s_sample;
  logic s_ready, bclk_out, fsync_out, b;
  logic [31:0] seed;
  int error_cnt, compares;
  sspt_sample_type pend[$];
  logic [162:0] expq[$];

  sspt_tx_format #(.BCLK_HALF_DIV(4), .FIFO_DEPTH(16)) DUT (
    .ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .controller_mode(controller_mode),
    .frame_format_select(frame_format_select), .word_length_select(word_length_select),
    .bit_clock_polarity(bit_clock_polarity), .ext_bclk(ext_bclk), .ext_fsync(ext_fsync),
    .bclk_out(bclk_out), .fsync_out(fsync_out), .dout_pri(dout_pri), .dout_pri_oe(dout_pri_oe),
    .secondary_data_pin(secondary_data_pin), .secondary_data_pin_oe(secondary_data_pin_oe),
    .keeper_en(keeper_en), .s_valid(s_valid), .s_ready(s_ready), .s_sample(s_sample));

  sspt_host_model host (
    .dout_pri(dout_pri), .dout_pri_oe(dout_pri_oe), .secondary_data_pin(secondary_data_pin),
    .secondary_data_pin_oe(secondary_data_pin_oe), .keeper_en(keeper_en),
    .ext_bclk(ext_bclk), .ext_fsync(ext_fsync));

  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [162:0] seen, input logic [162:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Register port and sample stream
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
    // One idle edge so a following write never re-raises the strobe at once
    @(posedge ref_clk) #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(posedge ref_clk) #1;
    check("register read", reg_rdata, exp);
  endtask

  // Valid stays up between pushes; the caller drops it
  task automatic push(input int ch, output bit ok);
    ok = (s_ready === 1'b1);
    if (ok)
    begin
      s_sample.chan = ch[2:0];
      s_sample.data = rnd();
      s_valid       = 1'b1;
      pend.push_back(s_sample);
      @(posedge ref_clk) #1;
    end
  endtask

  // ----------------------------------------
  // One frame: note every slot word, then let the host clock it
  // ----------------------------------------
  task automatic frame();
    int wl;
    logic [31:0] ones, dd, oo, fo, km;
    logic hit;
    wl   = (word_length_select == 2'h3) ? 32 : 16 + 4 * word_length_select;
    ones = (wl == 32) ? 32'hffffffff : (32'h1 << wl) - 32'h1;
    fo   = cfg0[BIT_IDLE_FILL] ? 32'h0 : ones;
    oo   = ones & ~{31'h0, cfg0[BIT_LAST_HOLD]};
    for (int s = 0; s < ((frame_format_select == 2'h0) ? 8 : 2); s++)
    begin
      hit = pend.size() > 0 && pend[0].chan == s;
      dd  = hit ? (pend[0].data >> (32 - wl)) & oo : 32'h0;
      km  = (cfg0[KEEPER_HI:KEEPER_LO] == 2'h1) ? ones : {31'h0, hit & cfg0[KEEPER_HI]};
      if (hit)
        void'(pend.pop_front());
      // Unselected pin of a live slot shows fill
      expq.push_back({s[2:0], km, (hit && !route[s]) ? oo : fo, (hit && !route[s]) ? dd : 32'h0,
                      (hit && route[s]) ? oo : fo, (hit && route[s]) ? dd : 32'h0});
    end
    host.run_frame(frame_format_select, word_length_select,
                   bit_clock_polarity ^ cfg0[BIT_LAUNCH_EDGE],
                   int'(off) + ((frame_format_select == 2'h1) ? 1 : 0));
    #200;
  endtask

  always @(host.word_done)
    check("slot word", host.word, (expq.size() > 0) ? expq.pop_front() : '1);

  // Mask of channels to load; an empty mask fills the buffer until refused
  task automatic scen(input logic [1:0] f, input logic [1:0] w, input logic p,
                      input logic [7:0] c, input logic [4:0] o, input logic [7:0] m,
                      input logic ctl);
    bit ok;
    int n;
    logic [31:0] r;
    frame_format_select = f;
    word_length_select  = w;
    bit_clock_polarity  = p;
    controller_mode     = ctl;
    cfg0 = c;
    off  = o;
    r    = rnd();
    route = r[7:0];
    wr(ADDR_FORMAT_CFG, c);
    wr(ADDR_OFFSET_CFG, {3'h0, o});
    wr(ADDR_ROUTE_CFG, route);
    rd(ADDR_FORMAT_CFG, c);
    rd(ADDR_OFFSET_CFG, {3'h0, o});
    rd(ADDR_ROUTE_CFG, route);
    check("keeper idle", keeper_en, c[KEEPER_HI:KEEPER_LO] == 2'h1);
    n  = 0;
    ok = 1'b1;
    for (int s = 0; s < 8; s++)
      if (m[s])
        push(s, ok);
    while (m == 8'h0 && ok && n < 40)
    begin
      push(n % 8, ok);
      n += ok;
    end
    s_valid = 1'b0;
    if (m == 8'h0)
      check("buffer refusal", n >= 16 && n < 40, 1'b1);
    do
      frame();
    while (pend.size() > 0);
  endtask

  initial
  begin
    seed = 32'hbc97b47c;
    {ref_clk, reg_wr, controller_mode, bit_clock_polarity, s_valid} = '0;
    {reg_addr, reg_wdata, cfg0, route, off} = '0;
    {frame_format_select, word_length_select} = '0;
    s_sample = '0;
    reset    = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 reset = 1'b0;
    @(posedge ref_clk) #1;
    rd(ADDR_FORMAT_CFG, CFG_RESET);
    rd(ADDR_OFFSET_CFG, CFG_RESET);
    rd(ADDR_ROUTE_CFG, CFG_RESET);
    check("frame sync idle", fsync_out, 1'b0);
    b = bclk_out;
    repeat (4) @(posedge ref_clk);
    #1;
    check("bit clock half period", bclk_out, !b);
    wr(8'h1e, 8'h5a);
    rd(8'h1e, 8'h00);
    scen(2'h0, 2'h0, 1'b0, 8'h00, 5'h00, 8'hff, 1'b0);
    scen(2'h0, 2'h3, 1'b1, 8'h80, 5'h05, 8'hff, 1'b0);
    scen(2'h0, 2'h1, 1'b0, 8'hf0, 5'h1f, 8'h25, 1'b0);
    scen(2'h0, 2'h2, 1'b0, 8'h19, 5'h00, 8'h00, 1'b1);
    scen(2'h2, 2'h0, 1'b0, 8'h08, 5'h03, 8'h03, 1'b0);
    scen(2'h1, 2'h2, 1'b1, 8'h00, 5'h00, 8'h03, 1'b0);
    check("words left", expq.size(), 0);
    complete_run();
  end

  initial
  begin
    #500000;
    error_cnt++;
    complete_run();
  end
endmodule
